// [shared/hbridge_defines.svh]
// Contract
// - In a current-limit mode, a conduction cycle whose phase current goes past the threshold is ended; the code ends only low-side conduction cycles.
// - Current limiting is off while the limit level sits at half the analog supply rail.
// - A level 0.4 V below half the rail gives the 8 A maximum, and levels between scale linearly.
// - A phase input held at full duty is chopped into cycles by an internal pulse so limiting still works.
// - The internal full-duty pulse runs at 20 kHz or 40 kHz, as the rate select pin chooses.
// - With both enables of a brushed pair high, both inputs low brake low and both inputs high drive high.
// - Sense feedback is given only while the low-side device conducts, so high-side loads get none.
// - The plain modes give sense feedback during low-side conduction but apply no limiting.
`ifndef HBRIDGE_DEFINES_SVH
`define HBRIDGE_DEFINES_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define CLK_SYS_HZ 50000000
`define FULL_DUTY_SLOW_HZ 20000
`define FULL_DUTY_FAST_HZ 40000
`define FULL_DUTY_SLOW_CYC (`CLK_SYS_HZ / `FULL_DUTY_SLOW_HZ)
`define FULL_DUTY_FAST_CYC (`CLK_SYS_HZ / `FULL_DUTY_FAST_HZ)

// ****************************************************************
// Current limit scaling
// ****************************************************************
`define LIMIT_SPAN_MV 400
`define LIMIT_MAX_MA 8000

// ****************************************************************
// Pin vector layout after synchronising
// ****************************************************************
`define PIN_IN_LSB 0
`define PIN_EN_LSB 3
`define PIN_MODE_LSB 6
`define PIN_RATE_BIT 8
`define PIN_COUNT 9

`endif

// [shared/hbridge_pkg.sv]
package hbridge_pkg;

    typedef enum logic [1:0] {
        MODE_SIX_PWM,
        MODE_THREE_PWM,
        MODE_SIX_PWM_LIMIT,
        MODE_THREE_PWM_LIMIT
    } pwm_mode_e;

    typedef logic [13:0] current_ma_t;
    typedef logic [11:0] level_mv_t;

endpackage : hbridge_pkg

// [core/half_bridge_current_limit_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
`include "hbridge_defines.svh"

module half_bridge_current_limit_ctrl #(
    parameter int PHASES = 3
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [2:0] phase_input,
    input wire logic [2:0] phase_enable,
    input wire logic [1:0] pwm_mode_sel,
    input wire logic full_duty_rate_sel,
    input wire hbridge_pkg::level_mv_t current_limit_level,
    input wire hbridge_pkg::level_mv_t analog_supply_rail,
    input wire hbridge_pkg::current_ma_t phase_current [3],
    output logic [2:0] phase_output,
    output logic [2:0] phase_output_oe,
    output logic [2:0] current_sense_valid,
    output hbridge_pkg::current_ma_t current_sense_output [3],
    output logic [2:0] limit_active
);
    import hbridge_pkg::*;

    localparam logic [11:0] SLOW_CYC = 12'(`FULL_DUTY_SLOW_CYC);
    localparam logic [11:0] FAST_CYC = 12'(`FULL_DUTY_FAST_CYC);
    localparam logic [12:0] SPAN_MV = 13'(`LIMIT_SPAN_MV);
    localparam logic [13:0] MA_PER_MV = 14'(`LIMIT_MAX_MA / `LIMIT_SPAN_MV);
    localparam logic [13:0] MAX_MA = 14'(`LIMIT_MAX_MA);

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    function automatic logic is_limit_mode(input pwm_mode_e mode);
        return (mode == MODE_SIX_PWM_LIMIT) || (mode == MODE_THREE_PWM_LIMIT);
    endfunction : is_limit_mode

    function automatic current_ma_t limit_threshold(input logic signed [12:0] offset);
        // Past the full span the threshold is pinned, so a low level cannot wrap the product.
        if (offset >= signed'(SPAN_MV)) begin
            return MAX_MA;
        end
        return 14'(offset[9:0] * MA_PER_MV);
    endfunction : limit_threshold

    function automatic logic [11:0] tick_last(input logic fast);
        // The count ends one short of the period because zero is a counted state.
        if (fast) begin
            return FAST_CYC - 12'h001;
        end
        return SLOW_CYC - 12'h001;
    endfunction : tick_last

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [`PIN_COUNT-1:0] pin_raw;
    // Three stages are used so that a metastable first stage never reaches the compare.
    logic [`PIN_COUNT-1:0] sync1_ff;
    logic [`PIN_COUNT-1:0] sync2_ff;
    logic [`PIN_COUNT-1:0] sync3_ff;
    logic [`PIN_COUNT-1:0] pin_ff;
    logic [`PIN_COUNT-1:0] nxt_sync1;
    logic [`PIN_COUNT-1:0] nxt_sync2;
    logic [`PIN_COUNT-1:0] nxt_sync3;
    logic [`PIN_COUNT-1:0] nxt_pin;

    assign pin_raw = {full_duty_rate_sel, pwm_mode_sel, phase_enable, phase_input};

    always_comb begin
        nxt_sync1 = pin_raw;
        nxt_sync2 = sync1_ff;
        nxt_sync3 = sync2_ff;
        nxt_pin = pin_ff;
        // A pin change is accepted only once two late stages agree.
        for (int b = 0; b < `PIN_COUNT; b++) begin
            if (sync2_ff[b] == sync3_ff[b]) begin
                nxt_pin[b] = sync3_ff[b];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            pin_ff <= '0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            sync3_ff <= nxt_sync3;
            pin_ff <= nxt_pin;
        end
    end

    // ****************************************************************
    // Accepted pin values
    // ****************************************************************
    logic [2:0] in_s;
    logic [2:0] en_s;
    pwm_mode_e mode_s;
    logic limit_mode;
    assign in_s = pin_ff[`PIN_IN_LSB +: 3];
    assign en_s = pin_ff[`PIN_EN_LSB +: 3];
    assign mode_s = pwm_mode_e'(pin_ff[`PIN_MODE_LSB +: 2]);
    // The plain modes share the decode but never enable the limiter.
    assign limit_mode = is_limit_mode(mode_s);

    // ****************************************************************
    // Threshold from the limit level
    // ****************************************************************
    logic signed [12:0] offset_mv;
    logic limit_on;
    current_ma_t threshold_ma;

    always_comb begin
        offset_mv = signed'({2'b00, analog_supply_rail[11:1]})
                  - signed'({1'b0, current_limit_level});
        // At or above mid-rail the limiter stands down.
        limit_on = limit_mode && (offset_mv > 13'sd0);
        threshold_ma = limit_threshold(offset_mv);
    end

    // ****************************************************************
    // Internal full-duty pulse
    // ****************************************************************
    // The pulse runs free from reset; a user sees the first chop release at any phase of it.
    logic [11:0] tick_cnt_ff;
    logic [11:0] nxt_tick_cnt;
    logic tick_ff;
    logic nxt_tick;

    always_comb begin
        nxt_tick = 1'b0;
        nxt_tick_cnt = tick_cnt_ff + 12'h001;
        if (tick_cnt_ff >= tick_last(pin_ff[`PIN_RATE_BIT])) begin
            nxt_tick_cnt = 12'h000;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tick_cnt_ff <= 12'h000;
            tick_ff <= 1'b0;
        end else begin
            tick_cnt_ff <= nxt_tick_cnt;
            tick_ff <= nxt_tick;
        end
    end

    // ****************************************************************
    // Phase decode, chopping and sense
    // ****************************************************************
    // Chopping only acts on low-side conduction, since high-side current is never sensed.
    logic [2:0] in_prev_ff;
    logic [2:0] nxt_in_prev;
    logic [2:0] chop_ff;
    logic [2:0] nxt_chop;
    logic [2:0] out_ff;
    logic [2:0] oe_ff;
    logic [2:0] sv_ff;
    logic [2:0] nxt_out;
    logic [2:0] nxt_oe;
    logic [2:0] nxt_sv;
    current_ma_t so_ff [3];
    current_ma_t nxt_so [3];

    always_comb begin
        nxt_in_prev = in_s;
        for (int p = 0; p < PHASES; p++) begin
            nxt_chop[p] = chop_ff[p];
            // A new input edge or the internal pulse opens a fresh cycle.
            if ((in_s[p] != in_prev_ff[p]) || tick_ff || !limit_on || !en_s[p]) begin
                nxt_chop[p] = 1'b0;
            end else if (oe_ff[p] && !out_ff[p] && (phase_current[p] > threshold_ma)) begin
                nxt_chop[p] = 1'b1;
            end
            nxt_oe[p] = en_s[p] && !nxt_chop[p];
            nxt_out[p] = en_s[p] && in_s[p];
            // Only the low-side path passes the sense device.
            nxt_sv[p] = nxt_oe[p] && !nxt_out[p];
            nxt_so[p] = nxt_sv[p] ? phase_current[p] : '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            in_prev_ff <= '0;
            chop_ff <= '0;
            out_ff <= '0;
            oe_ff <= '0;
            sv_ff <= '0;
            for (int p = 0; p < PHASES; p++) begin
                so_ff[p] <= '0;
            end
        end else begin
            in_prev_ff <= nxt_in_prev;
            chop_ff <= nxt_chop;
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
            sv_ff <= nxt_sv;
            so_ff <= nxt_so;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Every output is a register, so the pins never show decode glitches.
    assign phase_output = out_ff;
    assign phase_output_oe = oe_ff;
    assign current_sense_valid = sv_ff;
    assign current_sense_output = so_ff;
    assign limit_active = chop_ff;

endmodule : half_bridge_current_limit_ctrl
`default_nettype wire

// [bench/mcu_drive.sv]
`timescale 1ns/1ns
`default_nettype none
module mcu_drive (
    input wire logic clk_sys,
    input wire logic [2:0] want_in,
    input wire logic [2:0] want_en,
    output var logic [2:0] phase_input = 3'h0,
    output var logic [2:0] phase_enable = 3'h0
);
    // Pins move only just after an edge and then hold, like a port register of the controller.
    always @(posedge clk_sys) begin
        #2;
        phase_input <= want_in;
        phase_enable <= want_en;
    end
endmodule : mcu_drive
`default_nettype wire

// [bench/hbridge_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module hbridge_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [2:0] phase_input,
    input wire logic [2:0] phase_enable,
    input wire logic [1:0] pwm_mode_sel,
    input wire hbridge_pkg::level_mv_t current_limit_level,
    input wire hbridge_pkg::level_mv_t analog_supply_rail,
    input wire hbridge_pkg::current_ma_t phase_current [3],
    input wire logic [2:0] phase_output,
    input wire logic [2:0] phase_output_oe,
    input wire logic [2:0] current_sense_valid,
    input wire hbridge_pkg::current_ma_t current_sense_output [3],
    input wire logic [2:0] limit_active
);
    import hbridge_pkg::*;
    int half;
    int thr;
    // The threshold is rebuilt here so that a scaling slip in the design cannot hide.
    always_comb begin
        half = int'(analog_supply_rail >> 1);
        thr = (half - int'(current_limit_level)) * 20;
        if (thr > 8000) begin
            thr = 8000;
        end
    end
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    en_gate_a: assert property ((phase_output_oe & ~$past(phase_enable, 5)) == 3'h0)
        else $error("phase driven while its enable was low");
    out_gate_a: assert property ((phase_output & ~$past(phase_enable & phase_input, 5)) == 3'h0)
        else $error("phase driven high without enable and input high");
    low_sense_a: assert property (current_sense_valid == (phase_output_oe & ~phase_output))
        else $error("sense valid differs from low side conduction");
    sense_copy_a: assert property (current_sense_valid[0] |-> current_sense_output[0] == $past(phase_current[0]))
        else $error("sense output is not the phase current");
    sense_zero_a: assert property (!current_sense_valid[1] |-> current_sense_output[1] == 14'h0)
        else $error("sense output given without low side conduction");
    plain_a: assert property (!pwm_mode_sel[1] && !$past(pwm_mode_sel[1], 8) |-> limit_active == 3'h0)
        else $error("chopping in a plain mode");
    off_a: assert property ((int'(current_limit_level) >= half) [*3] |-> limit_active == 3'h0)
        else $error("chopping with the level at half rail");
    chop_a: assert property ($rose(limit_active[0]) |-> !phase_output_oe[0] && !current_sense_valid[0])
        else $error("chop did not release the output");
    cause_a: assert property ($rose(limit_active[0]) |-> $past(int'(phase_current[0]) > thr && thr > 0))
        else $error("chop without current above threshold");
    chop_c: cover property ($rose(limit_active[0]));
    brake_c: cover property (phase_output_oe == 3'h7 && phase_output == 3'h0);
    drive_c: cover property (phase_output == 3'h7);
endmodule : hbridge_chk
bind half_bridge_current_limit_ctrl hbridge_chk chk_i (.clk_sys, .rst_n, .phase_input, .phase_enable,
    .pwm_mode_sel, .current_limit_level, .analog_supply_rail, .phase_current, .phase_output,
    .phase_output_oe, .current_sense_valid, .current_sense_output, .limit_active);
`default_nettype wire

// [bench/tb_half_bridge_current_limit_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_half_bridge_current_limit_ctrl;
    import hbridge_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] want_in = 3'h0, want_en = 3'h0, phase_input, phase_enable;
    logic [2:0] phase_output, phase_output_oe, current_sense_valid, limit_active;
    logic [1:0] pwm_mode_sel = 2'h0;
    logic full_duty_rate_sel = 1'b0;
    level_mv_t current_limit_level = 12'h60E, analog_supply_rail = 12'hCE4;
    current_ma_t phase_current [3] = '{14'h0, 14'h0, 14'h0};
    current_ma_t current_sense_output [3];
    int bad_count = 0;
    int compares = 0;
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    mcu_drive mcu (.clk_sys, .want_in, .want_en, .phase_input, .phase_enable);
    half_bridge_current_limit_ctrl dut (.clk_sys, .rst_n, .phase_input, .phase_enable,
        .pwm_mode_sel, .full_duty_rate_sel, .current_limit_level, .analog_supply_rail,
        .phase_current, .phase_output, .phase_output_oe, .current_sense_valid,
        .current_sense_output, .limit_active);
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask : step
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wrap_up;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    task automatic t_decode;
        logic [5:0] pat [4] = '{6'o70, 6'o77, 6'o35, 6'o07};
        foreach (pat[i]) begin
            {want_en, want_in} = pat[i];
            step(9);
            chk("oe", want_en, phase_output_oe);
            chk("out", want_en & want_in, phase_output);
            chk("sense_valid", want_en & ~want_in, current_sense_valid);
        end
        $display("decode test done");
    endtask : t_decode
    task automatic t_sense;
        want_en = 3'h7;
        for (int m = 0; m < 2; m++) begin
            pwm_mode_sel = 2'(m);
            phase_current = '{14'h834, 14'h834, 14'h834};
            want_in = 3'h1;
            step(9);
            chk("sense1", 14'h834, current_sense_output[1]);
            chk("sense2", 14'h834, current_sense_output[2]);
            chk("sense0", 14'h0, current_sense_output[0]);
            chk("limit", 3'h0, limit_active);
        end
        $display("sense test done");
    endtask : t_sense
    task automatic t_limit;
        level_mv_t lv [2] = '{12'h60E, 12'h4E2};
        for (int m = 2; m < 4; m++) begin
            pwm_mode_sel = 2'(m);
            want_in = 3'h0;
            for (int r = 0; r < 2; r++) begin
                current_limit_level = lv[r];
                phase_current = r ? '{14'h1F41, 14'h1F40, 14'h0} : '{14'h834, 14'h76C, 14'h7D0};
                step(9);
                chk("limit", 3'h1, limit_active);
                chk("oe", 3'h6, phase_output_oe);
            end
        end
        pwm_mode_sel = 2'h2;
        current_limit_level = 12'h672;
        phase_current = '{14'h3FFF, 14'h3FFF, 14'h3FFF};
        step(9);
        chk("limit_off", 3'h0, limit_active);
        $display("limit test done");
    endtask : t_limit
    task automatic t_tick(input logic r);
        int n;
        current_limit_level = 12'h60E;
        phase_current = '{14'h834, 14'h0, 14'h0};
        full_duty_rate_sel = r;
        step(9);
        repeat (2) begin
            n = 0;
            while (limit_active[0] === 1'b1 && n < 3000) begin
                step(1);
                n++;
            end
            while (limit_active[0] !== 1'b1 && n < 3000) begin
                step(1);
                n++;
            end
        end
        chk("tick_period", r ? 16'd1250 : 16'd2500, n[15:0]);
        $display("full duty tick test done");
    endtask : t_tick
    initial begin
        #1000000;
        bad_count++;
        wrap_up();
    end
    initial begin
        step(6);
        chk("reset_oe", 3'h0, phase_output_oe);
        rst_n = 1'b1;
        t_decode();
        t_sense();
        t_limit();
        t_tick(1'b0);
        t_tick(1'b1);
        wrap_up();
    end
endmodule : tb_half_bridge_current_limit_ctrl
`default_nettype wire
